// ---- hdl/break_interrupt_entry.sv ----
`timescale 1ns/1ps
// Functional notes
// - Hardware break vectors to base plus 0x18
// - Break return address goes to R16
// - Break sets active flag, blocks interrupts
// - Maskable break needs break/exception flags clear
// - Nonmaskable break is taken unconditionally
// - Return from break clears break flag
// - Source holds maskable break until taken
// - Nonmaskable break pulses exactly one cycle
// - Debug software break ignores vector, flag
// - Entries save and clear modes, reservation
// - Interrupt needs enable flag set
// - Interrupt vectors to base+0x10 or input
// - Interrupt saves R14, clears enable
// - Return from interrupt sets enable
// - Interrupt ignored during break or exception
// - Interrupt level or edge by parameter
// - Level source holds until vector taken
// - Edge latched; low cycle before next
// - Edge latched regardless of enable flag
// - Vectored ack codes 01, 10, 11
// - Ack codes last one cycle
// - User vector base+0x8 via branch-link
// - Exception entry sets active, clears enable
module break_interrupt_entry
  import brk_irq_pkg::*;
#(
  parameter logic [ADDR_W-1:0] vector_base_param = VECTOR_BASE_RESET,
  parameter int debug_level_param = 0,
  parameter int irq_mode_param = 1,
  parameter bit irq_edge_select_param = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  brk_irq_if.device link,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic redirect_out,
  output logic [ADDR_W-1:0] redirect_addr_out,
  output logic [REG_IDX_W-1:0] ret_reg_out,
  output logic [ADDR_W-1:0] ret_addr_out,
  output logic ret_write_out,
  output logic sw_break_out,
  output logic [1:0] irq_ack_out
);
  logic break_active_flag;
  logic exception_active_flag;
  logic irq_enable_flag;
  logic exc_enable_flag;
  logic user_mode_flag;
  logic virtual_mode_flag;
  logic saved_user_mode;
  logic saved_virtual_mode;
  logic reservation;
  logic [ADDR_W-1:0] decode_pc;
  logic edge_pending;
  logic irq_request;
  logic take_nm;
  logic take_mbrk;
  logic take_irq;
  logic take_user;
  logic any_entry;
  logic cmd_wr;
  logic [2:0] cmd;
  logic [1:0] next_ack;
  logic [ADDR_W-1:0] irq_target;

  ////////////////////////////////////////////////////////////////
  assign cmd_wr = wr_in && (addr_in == A_CMD);
  assign cmd = cmd_wr ? wdata_in[2:0] : OP_NONE;

  irq_edge_latch u_edge (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .edge_mode_in(irq_edge_select_param),
    .irq_in(link.irq),
    .taken_in(take_irq),
    .pending_out(edge_pending)
  );

  assign irq_request = irq_edge_select_param ? edge_pending : link.irq;
  // Priority: nonmaskable break, maskable break, interrupt, user vector
  assign take_nm = link.nonmaskable_break;
  assign take_mbrk = !take_nm && link.maskable_break && !break_active_flag && !exception_active_flag;
  assign take_irq = !take_nm && !take_mbrk && irq_request && irq_enable_flag
                    && !break_active_flag && !exception_active_flag;
  assign take_user = !take_nm && !take_mbrk && !take_irq && (cmd == OP_USER_VEC);
  assign any_entry = take_nm || take_mbrk || take_irq || take_user;
  assign irq_target = (irq_mode_param == IRQ_MODE_VECTORED) ? link.irq_vector
                      : vector_base_param + OFS_IRQ_VECTOR;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      decode_pc <= '0;
    end else if (wr_in && addr_in == A_PC) begin
      decode_pc <= wdata_in;
    end
  end

  // Redirect of decode stage and return address write
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      redirect_out <= 1'b0;
      redirect_addr_out <= '0;
      ret_reg_out <= '0;
      ret_addr_out <= '0;
      ret_write_out <= 1'b0;
    end else begin
      redirect_out <= any_entry;
      ret_write_out <= any_entry;
      ret_addr_out <= decode_pc;
      if (take_nm || take_mbrk) begin
        redirect_addr_out <= vector_base_param + OFS_BREAK_VECTOR;
        ret_reg_out <= REG_BREAK_RETURN;
      end else if (take_irq) begin
        redirect_addr_out <= irq_target;
        ret_reg_out <= REG_IRQ_RETURN;
      end else if (take_user) begin
        redirect_addr_out <= vector_base_param + OFS_USER_VECTOR;
        ret_reg_out <= wdata_in[8] ? wdata_in[REG_IDX_W+8:9] : REG_USER_RETURN;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sw_break_out <= 1'b0;
    end else begin
      sw_break_out <= (debug_level_param > 0) && (cmd == OP_SW_BREAK);
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      break_active_flag <= 1'b0;
    end else if (take_nm || take_mbrk) begin
      break_active_flag <= 1'b1;
    end else if (cmd == OP_RET_BREAK) begin
      break_active_flag <= 1'b0;
    end else if (cmd == OP_SW_BREAK && debug_level_param == 0) begin
      break_active_flag <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      exception_active_flag <= 1'b0;
      exc_enable_flag <= 1'b0;
    end else if (cmd == OP_EXC_ENTER) begin
      exception_active_flag <= 1'b1;
      exc_enable_flag <= 1'b0;
    end else if (cmd == OP_EXC_RETURN) begin
      exception_active_flag <= 1'b0;
      exc_enable_flag <= 1'b1;
    end else if (wr_in && addr_in == A_MODE) begin
      exc_enable_flag <= wdata_in[ST_EE];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      irq_enable_flag <= 1'b0;
    end else if (take_irq) begin
      irq_enable_flag <= 1'b0;
    end else if (cmd == OP_RET_IRQ || cmd == OP_SET_IRQ_EN) begin
      irq_enable_flag <= 1'b1;
    end
  end

  // Mode save; return instructions restore from the saved copies
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      user_mode_flag <= 1'b0;
      virtual_mode_flag <= 1'b0;
      saved_user_mode <= 1'b0;
      saved_virtual_mode <= 1'b0;
      reservation <= 1'b0;
    end else if (any_entry || cmd == OP_EXC_ENTER) begin
      saved_user_mode <= user_mode_flag;
      saved_virtual_mode <= virtual_mode_flag;
      user_mode_flag <= 1'b0;
      virtual_mode_flag <= 1'b0;
      reservation <= 1'b0;
    end else if (cmd == OP_RET_BREAK || cmd == OP_RET_IRQ || cmd == OP_EXC_RETURN) begin
      user_mode_flag <= saved_user_mode;
      virtual_mode_flag <= saved_virtual_mode;
    end else if (wr_in && addr_in == A_MODE) begin
      user_mode_flag <= wdata_in[ST_USER];
      virtual_mode_flag <= wdata_in[ST_VIRT];
      reservation <= wdata_in[ST_RES];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Ack codes only in vectored mode, one cycle each
  always_comb begin
    next_ack = ACK_IDLE;
    if (irq_mode_param == IRQ_MODE_VECTORED) begin
      if (take_irq) begin
        next_ack = ACK_TAKEN;
      end else if (cmd == OP_RET_IRQ) begin
        next_ack = ACK_RETURN;
      end else if (cmd == OP_SET_IRQ_EN && !irq_enable_flag) begin
        next_ack = ACK_REENABLE;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      irq_ack_out <= ACK_IDLE;
    end else begin
      irq_ack_out <= next_ack;
    end
  end
  assign link.irq_ack = irq_ack_out;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        A_STATUS: rdata_out <= {22'h0, edge_pending, reservation, saved_virtual_mode, saved_user_mode,
                               virtual_mode_flag, user_mode_flag, exc_enable_flag, irq_enable_flag,
                               exception_active_flag, break_active_flag};
        A_PC: rdata_out <= decode_pc;
        A_REDIRECT: rdata_out <= redirect_addr_out;
        A_RETREG: rdata_out <= {27'h0, ret_reg_out};
        A_RETADDR: rdata_out <= ret_addr_out;
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end
endmodule

// ---- hdl/brk_irq_pkg.sv ----
package brk_irq_pkg;
  localparam int ADDR_W = 32;
  localparam int REG_IDX_W = 5;
  localparam logic [ADDR_W-1:0] VECTOR_BASE_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] OFS_USER_VECTOR = 32'h0000_0008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_VECTOR = 32'h0000_0010;
  localparam logic [ADDR_W-1:0] OFS_BREAK_VECTOR = 32'h0000_0018;
  localparam logic [REG_IDX_W-1:0] REG_IRQ_RETURN = 5'h0E;
  localparam logic [REG_IDX_W-1:0] REG_USER_RETURN = 5'h0F;
  localparam logic [REG_IDX_W-1:0] REG_BREAK_RETURN = 5'h10;
  localparam logic [1:0] ACK_IDLE = 2'h0;
  localparam logic [1:0] ACK_TAKEN = 2'h1;
  localparam logic [1:0] ACK_RETURN = 2'h2;
  localparam logic [1:0] ACK_REENABLE = 2'h3;
  localparam int IRQ_MODE_VECTORED = 2;
  // Operation codes on the software-side port of the device end
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_RET_BREAK = 3'h1;
  localparam logic [2:0] OP_RET_IRQ = 3'h2;
  localparam logic [2:0] OP_SET_IRQ_EN = 3'h3;
  localparam logic [2:0] OP_USER_VEC = 3'h4;
  localparam logic [2:0] OP_SW_BREAK = 3'h5;
  localparam logic [2:0] OP_EXC_ENTER = 3'h6;
  localparam logic [2:0] OP_EXC_RETURN = 3'h7;
  // Status register bit positions (device end)
  localparam int ST_BRK_ACT = 0;
  localparam int ST_EXC_ACT = 1;
  localparam int ST_IRQ_EN = 2;
  localparam int ST_EE = 3;
  localparam int ST_USER = 4;
  localparam int ST_VIRT = 5;
  localparam int ST_UMS = 6;
  localparam int ST_VMS = 7;
  localparam int ST_RES = 8;
  localparam int ST_PEND = 9;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // Software port addresses
  localparam logic [3:0] A_CMD = 4'h0;
  localparam logic [3:0] A_STATUS = 4'h1;
  localparam logic [3:0] A_MODE = 4'h2;
  localparam logic [3:0] A_PC = 4'h3;
  localparam logic [3:0] A_REDIRECT = 4'h4;
  localparam logic [3:0] A_RETREG = 4'h5;
  localparam logic [3:0] A_RETADDR = 4'h6;
  localparam logic [3:0] A_VECTOR = 4'h7;
  localparam logic [3:0] A_ACKLOG = 4'h8;
endpackage

// ---- hdl/brk_irq_if.sv ----
`timescale 1ns/1ps
interface brk_irq_if;
  import brk_irq_pkg::*;
  logic maskable_break;
  logic nonmaskable_break;
  logic irq;
  logic [ADDR_W-1:0] irq_vector;
  logic [1:0] irq_ack;
  modport device (input maskable_break, input nonmaskable_break, input irq, input irq_vector, output irq_ack);
  modport source (output maskable_break, output nonmaskable_break, output irq, output irq_vector, input irq_ack);
endinterface

// ---- hdl/irq_edge_latch.sv ----
`timescale 1ns/1ps
module irq_edge_latch (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic edge_mode_in,
  input wire logic irq_in,
  input wire logic taken_in,
  output logic pending_out
);
  logic irq_prev;
  logic edge_seen;

  assign edge_seen = irq_in & ~irq_prev;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      irq_prev <= 1'b0;
    end else begin
      irq_prev <= irq_in;
    end
  end

  // Set beats the clear of a taken request; latch ignores enable
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pending_out <= 1'b0;
    end else if (!edge_mode_in) begin
      pending_out <= 1'b0;
    end else if (edge_seen) begin
      pending_out <= 1'b1;
    end else if (taken_in) begin
      pending_out <= 1'b0;
    end
  end
endmodule

// ---- hdl/break_irq_source.sv ----
`timescale 1ns/1ps
module break_irq_source
  import brk_irq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  brk_irq_if.source link,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic break_taken_in
);
  logic mbrk;
  logic nmbrk;
  logic irq_line;
  logic [ADDR_W-1:0] vector;
  logic [1:0] last_ack;

  // Maskable break held until taken, nonmaskable one cycle
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mbrk <= 1'b0;
      nmbrk <= 1'b0;
    end else begin
      nmbrk <= wr_in && addr_in == A_CMD && wdata_in[1];
      if (wr_in && addr_in == A_CMD && wdata_in[0]) begin
        mbrk <= 1'b1;
      end else if (break_taken_in) begin
        mbrk <= 1'b0;
      end
    end
  end

  // Irq level; software drops it (level) or pulses it (edge)
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      irq_line <= 1'b0;
      vector <= '0;
    end else begin
      if (wr_in && addr_in == A_CMD) begin
        irq_line <= wdata_in[2];
      end
      if (wr_in && addr_in == A_VECTOR) begin
        vector <= wdata_in;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      last_ack <= ACK_IDLE;
    end else if (link.irq_ack != ACK_IDLE) begin
      last_ack <= link.irq_ack;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rdata_out <= '0;
    end else if (rd_in && addr_in == A_ACKLOG) begin
      rdata_out <= {28'h0, last_ack, irq_line, mbrk};
    end else begin
      rdata_out <= '0;
    end
  end

  assign link.maskable_break = mbrk;
  assign link.nonmaskable_break = nmbrk;
  assign link.irq = irq_line;
  assign link.irq_vector = vector;
endmodule

// ---- verif/break_interrupt_entry_assertions.sv ----
`timescale 1ns/1ps
module break_interrupt_entry_checker
  import brk_irq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic maskable_break,
  input wire logic nonmaskable_break,
  input wire logic irq,
  input wire logic [ADDR_W-1:0] irq_vector,
  input wire logic [1:0] irq_ack
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  ////////////////////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property (irq_ack != ACK_IDLE |=> irq_ack == ACK_IDLE)
    else $error("acknowledge code held longer than one cycle");
  a_nmi_single_pulse: assert property ($rose(nonmaskable_break) |=> !nonmaskable_break)
    else $error("nonmaskable break longer than one cycle");
  a_ack_no_repeat: assert property (irq_ack == ACK_TAKEN |=> (irq_ack != ACK_TAKEN) [*2])
    else $error("taken code repeated");
  a_mbrk_holds: assert property ($rose(maskable_break) |=> maskable_break)
    else $error("maskable break dropped before it was taken");
  a_nmi_beats_irq: assert property (nonmaskable_break |=> irq_ack != ACK_TAKEN)
    else $error("interrupt taken beside a nonmaskable break");
  // Registered outputs must still show their reset value at the first edge out of reset
  a_quiet_after_reset: assert property ($rose(resetn_in) |-> irq_ack == ACK_IDLE && !nonmaskable_break)
    else $error("link outputs not idle after reset");

  ////////////////////////////////////////////////////////////////////////////
  c_vector_taken: cover property (irq_ack == ACK_TAKEN && $stable(irq_vector));
  c_reenable: cover property (irq_ack == ACK_REENABLE);
  c_breaks: cover property ($rose(maskable_break) ##[1:20] $rose(irq));
endmodule

// ---- verif/break_interrupt_entry_bench.sv ----
`timescale 1ns/1ps
module break_interrupt_entry_bench;
  import brk_irq_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 32'h0000_1000;
  localparam logic [ADDR_W-1:0] HANDLER = 32'h0000_4A00;
  logic core_clk_in, resetn_in, dev_wr, dev_rd, src_wr, src_rd, redirect, ret_write, sw_break;
  logic [3:0] dev_addr, src_addr, ack_log;
  logic [31:0] dev_wdata, src_wdata, dev_rdata, src_rdata, rd_val;
  logic [ADDR_W-1:0] redirect_addr, ret_addr, last_addr, last_ret;
  logic [REG_IDX_W-1:0] ret_reg, last_reg;
  logic [1:0] irq_ack;
  int n_redir, n_swbrk, n_fail, tests_run;

  brk_irq_if i_brk_irq_if ();
  break_interrupt_entry #(.vector_base_param(BASE), .debug_level_param(0), .irq_mode_param(IRQ_MODE_VECTORED),
    .irq_edge_select_param(1'b1)) i_break_interrupt_entry (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .link(i_brk_irq_if.device), .addr_in(dev_addr), .wdata_in(dev_wdata), .wr_in(dev_wr), .rd_in(dev_rd),
    .rdata_out(dev_rdata), .redirect_out(redirect), .redirect_addr_out(redirect_addr), .ret_reg_out(ret_reg),
    .ret_addr_out(ret_addr), .ret_write_out(ret_write), .sw_break_out(sw_break), .irq_ack_out(irq_ack));
  break_irq_source i_break_irq_source (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .link(i_brk_irq_if.source), .addr_in(src_addr), .wdata_in(src_wdata), .wr_in(src_wr), .rd_in(src_rd),
    .rdata_out(src_rdata), .break_taken_in(redirect && ret_reg == REG_BREAK_RETURN));
  break_interrupt_entry_checker i_break_interrupt_entry_checker (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .maskable_break(i_brk_irq_if.maskable_break),
    .nonmaskable_break(i_brk_irq_if.nonmaskable_break), .irq(i_brk_irq_if.irq),
    .irq_vector(i_brk_irq_if.irq_vector), .irq_ack(i_brk_irq_if.irq_ack));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  // Pulses last one cycle, so a monitor logs them instead of each task polling
  always @(posedge core_clk_in) begin
    if (redirect) begin
      n_redir++;
      last_addr = redirect_addr;
      last_reg = ret_reg;
      last_ret = ret_addr;
    end
    if (irq_ack != ACK_IDLE) ack_log[irq_ack] = 1'b1;
    if (sw_break) n_swbrk++;
    if (ret_write !== redirect) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, ret_write, redirect);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Trailing idle edge keeps strobes from being reassigned in one time step
  task automatic wr(input bit s, input logic [3:0] a, input logic [31:0] d);
    if (s) begin
      src_addr <= a;
      src_wdata <= d;
      src_wr <= 1'b1;
    end else begin
      dev_addr <= a;
      dev_wdata <= d;
      dev_wr <= 1'b1;
    end
    @(posedge core_clk_in);
    src_wr <= 1'b0;
    dev_wr <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic rd(input bit s, input logic [3:0] a);
    if (s) begin
      src_addr <= a;
      src_rd <= 1'b1;
    end else begin
      dev_addr <= a;
      dev_rd <= 1'b1;
    end
    @(posedge core_clk_in);
    src_rd <= 1'b0;
    dev_rd <= 1'b0;
    #1 rd_val = s ? src_rdata : dev_rdata;
    @(posedge core_clk_in);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic nmi_and_irq;
    wr(1, A_VECTOR, HANDLER);
    wr(0, A_PC, 32'h0000_0200);
    wr(1, A_CMD, 32'h0000_0002);
    idle(3);
    chk(n_redir, 1);
    chk(last_addr, BASE + OFS_BREAK_VECTOR);
    chk(32'(last_reg), 32'(REG_BREAK_RETURN));
    chk(last_ret, 32'h0000_0200);
    rd(0, A_STATUS);
    chk(32'(rd_val[ST_BRK_ACT]), 32'h1);
    ack_log = 4'h0;
    wr(0, A_CMD, 32'h0000_0003);
    wr(1, A_CMD, 32'h0000_0004);
    idle(3);
    chk(n_redir, 1);
    chk(32'(ack_log[ACK_REENABLE]), 32'h1);
    wr(1, A_CMD, 32'h0000_0002);
    idle(3);
    chk(n_redir, 2);
    wr(0, A_CMD, 32'h0000_0001);
    idle(3);
    chk(n_redir, 3);
    chk(last_addr, HANDLER);
    chk(32'(last_reg), 32'(REG_IRQ_RETURN));
    chk(32'(ack_log[ACK_TAKEN]), 32'h1);
    rd(0, A_STATUS);
    chk(32'(rd_val[ST_BRK_ACT]), 32'h0);
    chk(32'(rd_val[ST_IRQ_EN]), 32'h0);
    wr(0, A_CMD, 32'h0000_0002);
    idle(3);
    chk(32'(ack_log[ACK_RETURN]), 32'h1);
    chk(n_redir, 3);
    rd(0, A_STATUS);
    chk(32'(rd_val[ST_IRQ_EN]), 32'h1);
    rd(1, A_ACKLOG);
    chk(rd_val, {28'h0, ACK_RETURN, 2'h0});
    wr(1, A_CMD, 32'h0000_0000);
  endtask

  task automatic masked_break;
    int n0;
    wr(0, A_CMD, 32'h0000_0006);
    n0 = n_redir;
    wr(1, A_CMD, 32'h0000_0001);
    idle(4);
    chk(n_redir, n0);
    wr(0, A_CMD, 32'h0000_0007);
    idle(3);
    chk(n_redir, n0 + 1);
    chk(last_addr, BASE + OFS_BREAK_VECTOR);
    rd(1, A_ACKLOG);
    chk(32'(rd_val[0]), 32'h0);
    wr(1, A_CMD, 32'h0000_0000);
    wr(0, A_CMD, 32'h0000_0001);
    rd(0, A_STATUS);
    chk(32'(rd_val[ST_BRK_ACT]), 32'h0);
  endtask

  // Debug level is 0 here, so a software break only raises the break flag
  task automatic soft_break;
    int n0;
    n0 = n_redir;
    wr(0, A_CMD, 32'h0000_0005);
    idle(2);
    chk(n_redir, n0);
    chk(n_swbrk, 0);
    rd(0, A_STATUS);
    chk(32'(rd_val[ST_BRK_ACT]), 32'h1);
    wr(1, A_CMD, 32'h0000_0004);
    idle(3);
    chk(n_redir, n0);
    wr(0, A_CMD, 32'h0000_0001);
    idle(3);
    chk(n_redir, n0 + 1);
    chk(last_addr, HANDLER);
    wr(1, A_CMD, 32'h0000_0000);
    wr(0, A_CMD, 32'h0000_0002);
  endtask

  task automatic user_vector;
    wr(0, A_MODE, 32'h0000_0110);
    wr(0, A_CMD, 32'h0000_0004);
    idle(3);
    chk(last_addr, BASE + OFS_USER_VECTOR);
    chk(32'(last_reg), 32'(REG_USER_RETURN));
    rd(0, A_STATUS);
    chk({29'h0, rd_val[ST_UMS], rd_val[ST_USER], rd_val[ST_RES]}, 32'h0000_0004);
    rd(0, A_REDIRECT);
    chk(rd_val, BASE + OFS_USER_VECTOR);
    rd(0, A_RETADDR);
    chk(rd_val, 32'h0000_0200);
    wr(0, A_CMD, 32'h0000_0704);
    idle(3);
    chk(32'(last_reg), 32'h0000_0003);
    rd(0, A_RETREG);
    chk(rd_val, 32'h0000_0003);
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {resetn_in, dev_wr, dev_rd, src_wr, src_rd, n_redir, n_swbrk, n_fail, tests_run} = '0;
    {dev_addr, src_addr, dev_wdata, src_wdata, ack_log} = '0;
    repeat (12) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    @(posedge core_clk_in);
    rd(0, A_STATUS);
    chk(rd_val, 32'h0000_0000);
    nmi_and_irq();
    masked_break();
    soft_break();
    user_vector();
    give_verdict();
  end

  // Whole sequence needs about 120 cycles
  initial begin
    #(25 * 2000);
    n_fail++;
    give_verdict();
  end
endmodule
